// ---- dv/icd_bm_partner.sv ----
// Purpose: Expansion bus master model that drives address cycles into the decode block
// Assumes: Commands come from the bench on aclk
// Notes: Odd parity per address byte unless a bad one is asked for
`timescale 1ns/10ps

module icd_bm_partner (
  input wire logic aclk,
  input wire logic go,
  input wire logic [3:0] chan,
  input wire logic mem_sel,
  input wire logic mapped,
  input wire logic [31:0] addr,
  input wire logic bad_par,
  output logic bm_valid,
  output logic [3:0] bm_channel,
  output logic bm_mem_sel,
  output logic bm_mapped,
  output logic [31:0] bm_addr,
  output logic [3:0] bm_addr_par
);
  initial begin
    {bm_valid, bm_channel, bm_mem_sel, bm_mapped, bm_addr, bm_addr_par} = '0;
  end

  always @(posedge aclk) begin
    bm_valid <= go;
    if (go) begin
      bm_channel <= chan;
      bm_mem_sel <= mem_sel;
      bm_mapped <= mapped;
      bm_addr <= addr;
      for (int i = 0; i < 4; i++) begin
        bm_addr_par[i] <= ~^addr[8*i+:8] ^ (bad_par && i == 0);
      end
    end else begin
      // Released address and parity lines do not keep the last value; channel and select lines do
      bm_addr <= ~bm_addr;
      bm_addr_par <= ~bm_addr_par;
    end
  end
endmodule : icd_bm_partner

// ---- dv/icd_io_channel_address_decode_test.sv ----
// Purpose: Self-checking bench of the I/O channel address decode block
// Assumes: 50 MHz aclk, synchronous active low reset
// Notes: Expectations come from an integer model kept in the bench
`timescale 1ns/10ps

module icd_io_channel_address_decode_test
  import icd_pkg::*;
;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, cpu_ea, bus_cyc_addr, bm_addr, dma_addr, dma_cyc_addr, pm_addr, rd, r;
  logic [3:0] s_axi_wstrb, bm_channel, bm_addr_par, dma_channel, pm_chan;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic cpu_req, cpu_io_sel, cpu_alt_space, cpu_auth_ok, cpu_write, cpu_string;
  logic bus_cyc_valid, bus_cyc_mem, bus_cyc_write, fac_valid, fac_write, fac_string;
  logic [18:0] fac_offset;
  logic bm_valid, bm_mem_sel, bm_mapped, bm_proceed, bm_parity_err, pm_go, pm_mem, pm_mapped, pm_bad;
  logic dma_req, dma_write, dma_cyc_valid, dma_cyc_mem, dma_cyc_write, byte_order_mode_bit, irq;
  logic [14:0] en_m;
  logic [31:0] seed, la_m;
  logic [31:0] eas [6] = '{32'h0000_0000, 32'h0000_FFFF, 32'h0001_0000, 32'h0007_FFFF, 32'h0008_0000, 32'hFFFF_FFFF};
  int miscompares, checks, cycles, sts_m;

  icd_io_channel_address_decode icd_io_channel_address_decode_i (.*);
  icd_bm_partner icd_bm_partner_i (.aclk(aclk), .go(pm_go), .chan(pm_chan), .mem_sel(pm_mem),
    .mapped(pm_mapped), .addr(pm_addr), .bad_par(pm_bad), .bm_valid(bm_valid), .bm_channel(bm_channel),
    .bm_mem_sel(bm_mem_sel), .bm_mapped(bm_mapped), .bm_addr(bm_addr), .bm_addr_par(bm_addr_par));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic cmp1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask : cmp1

  task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : cmp32

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // ****************************************
  // Bus and request tasks
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] p);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    p = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] p);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    p = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : axi_rd

  task automatic cpu_acc(input logic [31:0] ea, input logic io, alt, au, wr, st);
    int er;
    er = !io ? 0 : !au ? 0 : ea < IO_LIMIT ? 1 : ea < FAC_LIMIT ? 2 : alt ? 0 : 3;
    if (io && !au) sts_m |= 2;
    if (io) la_m = ea;
    @(posedge aclk);
    {cpu_req, cpu_ea, cpu_io_sel, cpu_alt_space, cpu_auth_ok, cpu_write, cpu_string} <= {1'b1, ea, io, alt, au, wr, st};
    @(posedge aclk);
    cpu_req <= 0;
    #1;
    cmp1("bus_cyc_valid", er == 1 || er == 3, bus_cyc_valid);
    cmp1("fac_valid", er == 2, fac_valid);
    if (er == 1) cmp32("bus_io_addr", {16'h0000, ea[15:0]}, {16'h0000, bus_cyc_addr[15:0]});
    if (er == 3) cmp32("bus_mem_addr", ea, bus_cyc_addr);
    if (er == 1 || er == 3) cmp1("bus_cyc_mem", er == 3, bus_cyc_mem);
    if (er == 1 || er == 3) cmp1("bus_cyc_write", wr, bus_cyc_write);
    if (er == 2) cmp32("fac_offset", {13'h0000, ea[18:0]}, {13'h0000, fac_offset});
    if (er == 2) cmp1("fac_string", st, fac_string);
    if (er == 2) cmp1("fac_write", wr, fac_write);
  endtask : cpu_acc

  task automatic bm_acc(input logic [3:0] ch, input logic m, mp, bad);
    logic mon, ep;
    mon = !m || !mp;
    ep = mon && !bad && ch != CPU_CHANNEL && en_m[ch];
    if (mon && bad) sts_m |= 1;
    if (ch == CPU_CHANNEL) sts_m |= 4;
    @(posedge aclk);
    {pm_go, pm_chan, pm_mem, pm_mapped, pm_addr, pm_bad} <= {1'b1, ch, m, mp, xs(), bad};
    @(posedge aclk);
    pm_go <= 0;
    @(posedge aclk);
    #1;
    cmp1("bm_parity_err", mon && bad, bm_parity_err);
    cmp1("bm_proceed", ep, bm_proceed);
  endtask : bm_acc

  task automatic dma_acc(input logic [3:0] ch, input logic [31:0] a, input logic wr);
    logic ev;
    ev = ch != CPU_CHANNEL && en_m[ch];
    if (ch == CPU_CHANNEL) sts_m |= 4;
    @(posedge aclk);
    {dma_req, dma_channel, dma_addr, dma_write} <= {1'b1, ch, a, wr};
    @(posedge aclk);
    dma_req <= 0;
    #1;
    cmp1("dma_cyc_valid", ev, dma_cyc_valid);
    cmp1("dma_cyc_mem", 1'b1, dma_cyc_mem);
    cmp1("fac_valid", 1'b0, fac_valid);
    if (ev) cmp32("dma_cyc_addr", a, dma_cyc_addr);
    if (ev) cmp1("dma_cyc_write", wr, dma_cyc_write);
  endtask : dma_acc

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {cpu_req, cpu_ea, cpu_io_sel, cpu_alt_space, cpu_auth_ok, cpu_write, cpu_string} = '0;
    {dma_req, dma_channel, dma_addr, dma_write, pm_go, pm_chan, pm_mem, pm_mapped, pm_addr, pm_bad} = '0;
    {miscompares, checks, cycles, sts_m} = '0;
    en_m = '0;
    seed = 32'h0000_06E5;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 4; i++) begin
      axi_rd(8'(4 * i), rd, rsp);
      cmp32("reg_reset", 32'h0000_0000, rd);
    end
    axi_rd(8'h18, rd, rsp);
    cmp32("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    axi_wr(OFS_LAST_ROUTE, 32'hFFFF_FFFF, 4'hF, rsp);
    cmp32("read_only_resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    cmp1("byte_order_reset", 1'b0, byte_order_mode_bit);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      for (int c = 0; c < 8; c++) cpu_acc(eas[i], c[0], c[1], c[2], c[0] ^ c[1], c[1]);
    end
    repeat (64) begin
      r = xs();
      cpu_acc(r >> r[4:0], r[5] | r[6], r[7], r[8] | r[9], r[10], r[11]);
    end
    axi_rd(OFS_LAST_ADDR, rd, rsp);
    cmp32("last_addr", la_m, rd);
    $display("test processor decode done");
    r = xs();
    axi_wr(OFS_CHAN_EN, r, 4'hF, rsp);
    en_m = r[14:0];
    axi_wr(OFS_CHAN_EN, 32'h0000_0000, 4'h1, rsp);
    en_m[7:0] = 8'h00;
    axi_rd(OFS_CHAN_EN, rd, rsp);
    cmp32("chan_en", {17'h00000, en_m}, rd);
    for (int i = 0; i < 64; i++) begin
      r = xs();
      bm_acc(4'(i >> 2), i[0] && i < 60, i[1], r[0] && i < 60);
    end
    $display("test bus master done");
    for (int i = 0; i < 16; i++) dma_acc(4'(i), xs(), i[0]);
    $display("test dma done");
    axi_rd(OFS_STATUS, rd, rsp);
    cmp32("status", 32'(sts_m), rd);
    cmp1("irq_masked", 1'b0, irq);
    axi_wr(OFS_MASK, 32'h0000_0007, 4'hF, rsp);
    repeat (2) @(posedge aclk);
    #1;
    cmp1("irq_set", sts_m != 0, irq);
    axi_wr(OFS_STATUS, 32'(sts_m), 4'hF, rsp);
    sts_m = 0;
    repeat (2) @(posedge aclk);
    #1;
    cmp1("irq_cleared", 1'b0, irq);
    bm_acc(4'h0, 1'b0, 1'b0, 1'b1);
    @(posedge aclk);
    #1;
    cmp1("irq_parity", 1'b1, irq);
    axi_wr(OFS_MASK, 32'h0000_0006, 4'hF, rsp);
    repeat (2) @(posedge aclk);
    #1;
    cmp1("irq_remasked", 1'b0, irq);
    $display("test interrupts done");
    axi_wr(OFS_CTRL, 32'h0000_0001, 4'hF, rsp);
    axi_wr(OFS_CTRL, 32'h0000_0003, 4'hF, rsp);
    axi_wr(OFS_CTRL, 32'h0000_0000, 4'hF, rsp);
    @(posedge aclk);
    #1;
    cmp1("byte_order_locked", 1'b1, byte_order_mode_bit);
    $display("test byte order done");
    wrap_up();
  end
endmodule : icd_io_channel_address_decode_test

// ---- src/icd_dec_if.sv ----
// Purpose: Carries a processor address to the decoder and its route back
// Assumes: Purely combinational use
// Notes: requester drives the access, decoder returns the route
`timescale 1ns/10ps

interface icd_dec_if;
  import icd_pkg::*;
  logic [31:0] ea;
  logic io_sel;
  logic alt_space;
  logic auth_ok;
  icd_route_e route;

  modport requester (output ea, output io_sel, output alt_space, output auth_ok, input route);
  modport decoder (input ea, input io_sel, input alt_space, input auth_ok, output route);
endinterface : icd_dec_if

// ---- src/icd_ea_decode.sv ----
// Purpose: Classifies a processor effective address into one route
// Assumes: Fields stable while decoded
// Notes: Combinational only
`timescale 1ns/10ps

module icd_ea_decode
  import icd_pkg::*;
(
  icd_dec_if.decoder dif
);

  // ****************************************************************
  // Address space decode
  // ****************************************************************
  always_comb begin
    if (!dif.io_sel) begin
      dif.route = RT_SYSMEM; // [R16] [R6]
    end else if (!dif.auth_ok) begin
      dif.route = RT_DENIED; // [R18]
    end else if (dif.ea < IO_LIMIT) begin
      dif.route = RT_BUS_IO; // [R3]
    end else if (dif.ea < FAC_LIMIT) begin
      dif.route = RT_FACIL; // [R4]
    end else if (!dif.alt_space) begin
      dif.route = RT_BUS_MEM; // [R5]
    end else begin
      dif.route = RT_ALT; // [R5]
    end
  end

endmodule : icd_ea_decode

// ---- src/icd_io_channel_address_decode.sv ----
// Purpose: Steers processor, bus-master and DMA-slave addresses of an I/O channel controller
// Assumes: Requests arrive from logic on aclk; registers over AXI4-Lite
// Notes: All answers appear one cycle after the request
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps

module icd_io_channel_address_decode
  import icd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_req,
  input wire logic [31:0] cpu_ea,
  input wire logic cpu_io_sel,
  input wire logic cpu_alt_space,
  input wire logic cpu_auth_ok,
  input wire logic cpu_write,
  input wire logic cpu_string,
  output logic bus_cyc_valid,
  output logic [31:0] bus_cyc_addr,
  output logic bus_cyc_mem,
  output logic bus_cyc_write,
  output logic fac_valid,
  output logic [18:0] fac_offset,
  output logic fac_write,
  output logic fac_string,
  input wire logic bm_valid,
  input wire logic [3:0] bm_channel,
  input wire logic bm_mem_sel,
  input wire logic bm_mapped,
  input wire logic [31:0] bm_addr,
  input wire logic [3:0] bm_addr_par,
  output logic bm_proceed,
  output logic bm_parity_err,
  input wire logic dma_req,
  input wire logic [3:0] dma_channel,
  input wire logic [31:0] dma_addr,
  input wire logic dma_write,
  output logic dma_cyc_valid,
  output logic [31:0] dma_cyc_addr,
  output logic dma_cyc_mem,
  output logic dma_cyc_write,
  output logic byte_order_mode_bit,
  output logic irq
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic order_lock;
  logic [14:0] chan_en;
  logic [STS_W-1:0] status;
  logic [STS_W-1:0] mask;
  logic [STS_W-1:0] sts_set;
  logic [STS_W-1:0] sts_clr;
  icd_route_e last_route;
  logic [31:0] last_addr;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // ****************************************************************
  // Address decode of processor accesses
  // ****************************************************************
  icd_dec_if dif ();

  assign dif.ea = cpu_ea;
  assign dif.io_sel = cpu_io_sel;
  assign dif.alt_space = cpu_alt_space;
  assign dif.auth_ok = cpu_auth_ok;

  icd_ea_decode u_dec (
    .dif (dif)
  );

  // ****************************************************************
  // Processor route outputs
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_cyc_valid <= 1'h0;
      bus_cyc_addr <= 32'h0000_0000;
      bus_cyc_mem <= 1'h0;
      bus_cyc_write <= 1'h0;
      fac_valid <= 1'h0;
      fac_offset <= 19'h0_0000;
      fac_write <= 1'h0;
      fac_string <= 1'h0;
    end else begin
      bus_cyc_valid <= 1'h0;
      fac_valid <= 1'h0;
      if (cpu_req) begin
        bus_cyc_write <= cpu_write;
        fac_write <= cpu_write;
        fac_string <= cpu_string; // [R12]
        unique case (dif.route)
          RT_BUS_IO: begin
            bus_cyc_valid <= 1'h1; // [R3]
            bus_cyc_mem <= 1'h0;
            bus_cyc_addr <= {16'h0000, cpu_ea[15:0]}; // [R2]
          end
          RT_FACIL: begin
            fac_valid <= 1'h1; // [R4] [R11] [R12]
            fac_offset <= cpu_ea[18:0];
          end
          RT_BUS_MEM: begin
            bus_cyc_valid <= 1'h1; // [R5] [R6]
            bus_cyc_mem <= 1'h1;
            bus_cyc_addr <= cpu_ea; // [R1]
          end
          RT_SYSMEM, RT_ALT, RT_DENIED: begin
            bus_cyc_valid <= 1'h0; // [R16] [R18]
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_route <= RT_SYSMEM;
      last_addr <= 32'h0000_0000;
    end else if (cpu_req && cpu_io_sel) begin
      last_route <= dif.route;
      last_addr <= cpu_ea;
    end
  end

  // ****************************************************************
  // Bus master monitor
  // ****************************************************************
  logic [3:0] par_bad;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_par
      assign par_bad[gi] = ~(^{bm_addr[gi*8 +: 8], bm_addr_par[gi]});
    end
  endgenerate

  logic bm_chan_ok;
  logic bm_monitored;
  assign bm_chan_ok = (bm_channel != CPU_CHANNEL) && chan_en[bm_channel[3:0] == CPU_CHANNEL ? 4'h0 : bm_channel];
  assign bm_monitored = bm_valid && (!bm_mem_sel || !bm_mapped); // [R7] [R8]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bm_proceed <= 1'h0;
      bm_parity_err <= 1'h0;
    end else begin
      bm_parity_err <= bm_monitored && (|par_bad); // [R8] [R17]
      bm_proceed <= bm_monitored && !(|par_bad) && bm_chan_ok; // [R8] [R15] [R11]
    end
  end

  // ****************************************************************
  // DMA slave transfers
  // ****************************************************************
  logic dma_ok;
  assign dma_ok = dma_req && (dma_channel != CPU_CHANNEL) && chan_en[dma_channel == CPU_CHANNEL ? 4'h0 : dma_channel];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_cyc_valid <= 1'h0;
      dma_cyc_addr <= 32'h0000_0000;
      dma_cyc_mem <= 1'h1;
      dma_cyc_write <= 1'h0;
    end else begin
      dma_cyc_valid <= dma_ok; // [R15]
      dma_cyc_mem <= 1'h1; // [R9] [R10]
      if (dma_ok) begin
        dma_cyc_addr <= dma_addr; // [R9] [R11]
        dma_cyc_write <= dma_write;
      end
    end
  end

  // ****************************************************************
  // Status, mask and interrupt
  // ****************************************************************
  always_comb begin
    sts_set = '0;
    sts_set[STS_PARITY] = bm_monitored && (|par_bad); // [R17]
    sts_set[STS_DENIED] = cpu_req && (dif.route == RT_DENIED); // [R18]
    sts_set[STS_RESERVED] = (bm_valid && bm_channel == CPU_CHANNEL) || (dma_req && dma_channel == CPU_CHANNEL);
    sts_clr = '0;
    if (wr_hit && aw_addr == OFS_STATUS && w_strb[0]) begin
      sts_clr = w_data[STS_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
      irq <= 1'h0;
    end else begin
      status <= (status & ~sts_clr) | sts_set;
      irq <= |(((status & ~sts_clr) | sts_set) & mask);
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign wr_fire = aw_held && w_held && !s_axi_bvalid && !(s_axi_arvalid && s_axi_arready);
  assign wr_hit = wr_fire && (aw_addr == OFS_CTRL || aw_addr == OFS_CHAN_EN || aw_addr == OFS_STATUS
                  || aw_addr == OFS_MASK);

  always_comb begin
    wr_word = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      wr_word[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : rd_word[b*8 +: 8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'h0;
      s_axi_wready <= 1'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'h1;
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
        s_axi_awready <= 1'h0;
      end else if (!aw_held && !s_axi_bvalid) begin
        s_axi_awready <= 1'h1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'h1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'h0;
      end else if (!w_held && !s_axi_bvalid) begin
        s_axi_wready <= 1'h1;
      end
      if (wr_fire) begin
        aw_held <= 1'h0;
        w_held <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_order_mode_bit <= RST_ORDER;
      order_lock <= 1'h0;
      chan_en <= RST_CHAN_EN;
      mask <= RST_MASK;
    end else if (wr_hit) begin
      unique case (aw_addr)
        OFS_CTRL: begin
          if (!order_lock) begin
            byte_order_mode_bit <= wr_word[CTRL_ORDER_BIT]; // [R13] [R14]
          end
          order_lock <= order_lock | wr_word[CTRL_LOCK_BIT]; // [R13]
        end
        OFS_CHAN_EN: chan_en <= wr_word[14:0]; // [R15]
        OFS_MASK: mask <= wr_word[STS_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  logic [7:0] rd_sel;
  assign rd_sel = wr_fire ? aw_addr : {s_axi_araddr[7:2], 2'h0};

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'h1;
    unique case (rd_sel)
      OFS_CTRL: rd_word = {30'h0, order_lock, byte_order_mode_bit};
      OFS_CHAN_EN: rd_word = {17'h0_0000, chan_en};
      OFS_STATUS: rd_word = {29'h0, status};
      OFS_MASK: rd_word = {29'h0, mask};
      OFS_LAST_ROUTE: rd_word = {26'h000_0000, last_route};
      OFS_LAST_ADDR: rd_word = last_addr;
      default: rd_hit = 1'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'h0;
        s_axi_rvalid <= 1'h1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end else if (!s_axi_rvalid && !s_axi_arready && !wr_fire) begin
        s_axi_arready <= 1'h1;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_IO_ROUTE: assert property (cpu_req && cpu_io_sel && cpu_auth_ok && cpu_ea < IO_LIMIT |=> // [R3]
    bus_cyc_valid && !bus_cyc_mem && bus_cyc_addr[15:0] == $past(cpu_ea[15:0]) && !fac_valid)
    else $error("I/O region access did not give a bus I/O cycle");
  AST_FAC_ROUTE: assert property (cpu_req && cpu_io_sel && cpu_auth_ok && cpu_ea >= IO_LIMIT // [R4]
    && cpu_ea < FAC_LIMIT |=> fac_valid && !bus_cyc_valid && fac_offset == $past(cpu_ea[18:0]))
    else $error("Facility region access misrouted");
  AST_MEM_ROUTE: assert property (cpu_req && cpu_io_sel && cpu_auth_ok && cpu_ea >= FAC_LIMIT // [R5]
    && !cpu_alt_space |=> bus_cyc_valid && bus_cyc_mem && bus_cyc_addr == $past(cpu_ea))
    else $error("Bus memory access misrouted");
  AST_ALT_NO_BUS: assert property (cpu_req && cpu_io_sel && cpu_ea >= FAC_LIMIT && cpu_alt_space // [R5]
    |=> !bus_cyc_valid && !fac_valid)
    else $error("Alternate space access reached the bus");
  AST_SYSMEM_SKIP: assert property (cpu_req && !cpu_io_sel |=> !bus_cyc_valid && !fac_valid) // [R16]
    else $error("System memory access involved the controller");
  AST_DENIED: assert property (cpu_req && cpu_io_sel && !cpu_auth_ok |=> // [R18]
    !bus_cyc_valid && !fac_valid && status[STS_DENIED])
    else $error("Denied access not blocked or not reported");
  AST_DMA_MEM: assert property (dma_req && dma_channel != CPU_CHANNEL // [R9]
    && chan_en[dma_channel == CPU_CHANNEL ? 4'h0 : dma_channel]
    |=> dma_cyc_valid && dma_cyc_mem && dma_cyc_addr == $past(dma_addr))
    else $error("DMA transfer not a bus memory cycle");
  AST_BM_PARITY: assert property (bm_valid && (!bm_mem_sel || !bm_mapped) && |par_bad |=> // [R17]
    bm_parity_err && !bm_proceed ##1 status[STS_PARITY] || !status[STS_PARITY] && $past(sts_clr[STS_PARITY]))
    else $error("Address parity error not reported");
  AST_BM_RESERVED: assert property (bm_valid && bm_channel == CPU_CHANNEL |=> !bm_proceed) // [R15]
    else $error("Reserved channel granted to a bus master");
  AST_ORDER_LOCK: assert property (order_lock |=> $stable(byte_order_mode_bit) && order_lock) // [R13]
    else $error("Byte order changed after lock");

  COV_IO: cover property (cpu_req && dif.route == RT_BUS_IO ##1 bus_cyc_valid);
  COV_MEM: cover property (cpu_req && dif.route == RT_BUS_MEM ##1 bus_cyc_valid);
  COV_PAR: cover property (bm_parity_err ##1 irq);
  COV_DMA: cover property (dma_cyc_valid);

endmodule : icd_io_channel_address_decode

// ---- src/icd_pkg.sv ----
// Purpose: Constants and types of the I/O channel address decode block
// Assumes: One clock aclk at 50 MHz, synchronous active low reset
// Notes: Register map is reached over AXI4-Lite, one aligned word per register
//
// Notes on behaviour
// [R1] Bus memory address is full 32 bits
// [R2] Bus I/O uses 16 bits, upper undefined
// [R3] Processor address below 64 KB: bus I/O
// [R4] 64 KB up to 512 KB: own facilities
// [R5] 512 KB and above: bus memory unless alt
// [R6] Bus access only with I/O-select bit set
// [R7] Bus master drives memory/I/O select itself
// [R8] Unmapped master cycles: parity monitor, proceed if enabled
// [R9] DMA-slave transfers always target bus memory
// [R10] Never a bus I/O cycle for DMA
// [R11] Facilities decode only from processor accesses
// [R12] Facility commands by address, string or not
// [R13] Byte-order bit: 0 big, 1 little; boot only
// [R14] Address-modifying processors present true little-endian view
// [R15] Channel 0xF reserved for processor transfers
// [R16] I/O-select clear: system memory, controller uninvolved
// [R17] Address parity error reported as status event
// [R18] Failed authority blocks bus cycle and facility

package icd_pkg;

  // ****************************************************************
  // Address regions
  // ****************************************************************
  localparam logic [31:0] IO_LIMIT = 32'h0001_0000;
  localparam logic [31:0] FAC_LIMIT = 32'h0008_0000;
  localparam logic [3:0] CPU_CHANNEL = 4'hF;

  // ****************************************************************
  // Register offsets and fields
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAN_EN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_LAST_ROUTE = 8'h10;
  localparam logic [7:0] OFS_LAST_ADDR = 8'h14;

  localparam int CTRL_ORDER_BIT = 0;
  localparam int CTRL_LOCK_BIT = 1;
  localparam int STS_PARITY = 0;
  localparam int STS_DENIED = 1;
  localparam int STS_RESERVED = 2;
  localparam int STS_W = 3;

  localparam logic RST_ORDER = 1'h0;
  localparam logic [14:0] RST_CHAN_EN = 15'h0000;
  localparam logic [STS_W-1:0] RST_MASK = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Route of a processor access
  // ****************************************************************
  typedef enum logic [5:0] {
    RT_SYSMEM = 6'h01,
    RT_BUS_IO = 6'h02,
    RT_FACIL = 6'h04,
    RT_BUS_MEM = 6'h08,
    RT_ALT = 6'h10,
    RT_DENIED = 6'h20
  } icd_route_e;

endpackage : icd_pkg
